// [ncofs_pkg.sv]
package ncofs_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ACC_W = 32;
	localparam int PH_W = 12;
	localparam int NUM_PH = 4;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_FREQ_A = 8'h00;
	localparam logic [7:0] OFF_FREQ_B = 8'h04;
	localparam logic [7:0] OFF_PHASE0 = 8'h08;
	localparam logic [7:0] OFF_PHASE1 = 8'h0C;
	localparam logic [7:0] OFF_PHASE2 = 8'h10;
	localparam logic [7:0] OFF_PHASE3 = 8'h14;
	localparam logic [7:0] OFF_CTRL = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_ACC = 8'h20;
	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTRL_FREQ_BIT = 0;
	localparam int CTRL_PH_LO = 1;
	localparam int CTRL_PH_HI = 2;
	localparam int CTRL_USE_BITS = 3;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] FREQ_RST = 32'h0000_0000;
	localparam logic [11:0] PHASE_RST = 12'h000;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// ----------------------------------------
	// bus responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [ncofs_core.sv]
`timescale 1ns/1ps
module ncofs_core #(
	parameter int ACC_W = 32,
	parameter int PH_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// selected settings
	input wire logic [ACC_W-1:0] step,
	input wire logic [PH_W-1:0] offset,
	// results
	output logic [ACC_W-1:0] acc,
	output logic [PH_W-1:0] table_phase
);
	logic [ACC_W-1:0] next_acc;
	logic [PH_W-1:0] next_phase;

	assign next_acc = acc + step;
	assign next_phase = acc[ACC_W-1 -: PH_W] + offset;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= '0;
			table_phase <= '0;
		end else begin
			acc <= next_acc;
			table_phase <= next_phase;
		end
	end

	chk_acc_step: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> acc == $past(acc) + $past(step))
		else $error("accumulator did not advance by step");

	chk_phase_sum: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> table_phase == PH_W'($past(acc[ACC_W-1 -: PH_W]) + $past(offset)))
		else $error("table phase not offset sum");
endmodule // ncofs_core

// [ncofs_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - exactly one of the two frequency words drives the accumulator step.
// - the word choice comes from the pin or from a control bit.
// - the choice pin is sampled on each rising clock edge and acts only through that sample.
// - four phase offset registers exist and the chosen one is added before the table.
// - the two phase choice pins form a two-bit index of the offset register.
// - the phase index can instead come from two control bits.
// - the phase choice pins are sampled on rising edges and kept steady there.
// - phase advances by the selected step every clock period.
// - the accumulator is 32 bits and wraps modulo two to the thirty-second.
// - each offset is 12 bits and adds to the accumulator top bits.
// - the table phase is the top 12 bits.
// - the index is binary with the low pin as least significant bit.
module ncofs_top #(
	parameter int ACC_W = 32,
	parameter int PH_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// selection pins
	input wire logic freq_word_choice,
	input wire logic phase_choice_lo,
	input wire logic phase_choice_hi,
	// write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// oscillator outputs
	output logic [ACC_W-1:0] phase_acc,
	output logic [PH_W-1:0] table_phase
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [ACC_W-1:0] freq_word_a;
	logic [ACC_W-1:0] freq_word_b;
	logic [PH_W-1:0] phase_offset_reg [ncofs_pkg::NUM_PH];
	logic [3:0] ctrl;
	logic freq_pin_q;
	logic [1:0] phase_pin_q;
	logic [ACC_W-1:0] step;
	logic [PH_W-1:0] offset;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction
	function automatic logic is_phase(input logic [7:0] a);
		return a >= ncofs_pkg::OFF_PHASE0 && a <= ncofs_pkg::OFF_PHASE3 && a[1:0] == 2'h0;
	endfunction
	function automatic logic [1:0] phase_idx(input logic [7:0] a);
		return 2'((a - ncofs_pkg::OFF_PHASE0) >> 2);
	endfunction

	// ----------------------------------------
	// selection
	// ----------------------------------------
	wire use_bits = ctrl[ncofs_pkg::CTRL_USE_BITS];
	wire sel_b = use_bits ? ctrl[ncofs_pkg::CTRL_FREQ_BIT] : freq_pin_q;
	wire [1:0] sel_ph = use_bits ? {ctrl[ncofs_pkg::CTRL_PH_HI], ctrl[ncofs_pkg::CTRL_PH_LO]}
		: phase_pin_q;
	wire [ACC_W-1:0] next_step = sel_b ? freq_word_b : freq_word_a;
	wire [PH_W-1:0] next_offset = phase_offset_reg[sel_ph];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_pin_q <= 1'b0;
			phase_pin_q <= 2'h0;
			step <= '0;
			offset <= '0;
		end else begin
			freq_pin_q <= freq_word_choice;
			phase_pin_q <= {phase_choice_hi, phase_choice_lo};
			step <= next_step;
			offset <= next_offset;
		end
	end

	ncofs_core #(.ACC_W(ACC_W), .PH_W(PH_W)) u_core (
		.aclk(aclk),
		.aresetn(aresetn),
		.step(step),
		.offset(offset),
		.acc(phase_acc),
		.table_phase(table_phase)
	);

	// ----------------------------------------
	// axi write
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	wire [7:0] wa = aw_held ? aw_q : s_axi_awaddr;
	wire [31:0] wd = w_held ? wd_q : s_axi_wdata;
	wire [3:0] ws = w_held ? ws_q : s_axi_wstrb;
	wire have_aw = aw_held | (s_axi_awvalid & s_axi_awready);
	wire have_w = w_held | (s_axi_wvalid & s_axi_wready);
	wire do_wr = have_aw & have_w & ~s_axi_bvalid;
	wire [1:0] wr_idx = phase_idx(wa);
	wire wr_ph = is_phase(wa);
	wire wr_ok = wa == ncofs_pkg::OFF_FREQ_A || wa == ncofs_pkg::OFF_FREQ_B
		|| wr_ph || wa == ncofs_pkg::OFF_CTRL;
	wire [31:0] ph_old = {20'h0, phase_offset_reg[wr_idx]};
	wire [31:0] ph_new = merge(ph_old, wd, ws);
	wire [31:0] ctrl_new = merge({28'h0, ctrl}, wd, ws);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ncofs_pkg::RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			freq_word_a <= ncofs_pkg::FREQ_RST;
			freq_word_b <= ncofs_pkg::FREQ_RST;
			ctrl <= ncofs_pkg::CTRL_RST;
			for (int i = 0; i < ncofs_pkg::NUM_PH; i++) phase_offset_reg[i] <= ncofs_pkg::PHASE_RST;
		end else begin
			s_axi_awready <= ~have_aw & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= ~have_w & ~s_axi_wready & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			aw_held <= have_aw & ~do_wr;
			w_held <= have_w & ~do_wr;
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? ncofs_pkg::RESP_OKAY : ncofs_pkg::RESP_SLVERR;
				if (wa == ncofs_pkg::OFF_FREQ_A) freq_word_a <= merge(freq_word_a, wd, ws);
				if (wa == ncofs_pkg::OFF_FREQ_B) freq_word_b <= merge(freq_word_b, wd, ws);
				if (wr_ph) phase_offset_reg[wr_idx] <= ph_new[PH_W-1:0];
				if (wa == ncofs_pkg::OFF_CTRL) ctrl <= ctrl_new[3:0];
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi read
	// ----------------------------------------
	wire [7:0] ra = s_axi_araddr;
	wire [1:0] rd_idx = phase_idx(ra);
	wire rd_ph = is_phase(ra);
	wire [31:0] status = {29'h0, sel_ph, sel_b};
	wire [31:0] rd_val = ra == ncofs_pkg::OFF_FREQ_A ? freq_word_a
		: ra == ncofs_pkg::OFF_FREQ_B ? freq_word_b
		: rd_ph ? {20'h0, phase_offset_reg[rd_idx]}
		: ra == ncofs_pkg::OFF_CTRL ? {28'h0, ctrl}
		: ra == ncofs_pkg::OFF_STATUS ? status
		: ra == ncofs_pkg::OFF_ACC ? phase_acc : 32'h0000_0000;
	wire rd_ok = ra == ncofs_pkg::OFF_FREQ_A || ra == ncofs_pkg::OFF_FREQ_B || rd_ph
		|| ra == ncofs_pkg::OFF_CTRL || ra == ncofs_pkg::OFF_STATUS || ra == ncofs_pkg::OFF_ACC;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ncofs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? ncofs_pkg::RESP_OKAY : ncofs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_freq_select: assert property (@(posedge aclk) disable iff (!aresetn)
		step == freq_word_a || step == freq_word_b || $changed(freq_word_a) || $changed(freq_word_b)
		|| $past(!aresetn))
		else $error("step is neither frequency word");
	chk_pin_path: assert property (@(posedge aclk) disable iff (!aresetn)
		!use_bits ##1 ($stable(freq_word_a) && $stable(freq_word_b))
		|-> step == ($past(freq_word_choice, 2) ? freq_word_b : freq_word_a))
		else $error("pin choice not two cycles to step");
	chk_bit_path: assert property (@(posedge aclk) disable iff (!aresetn)
		use_bits |=> step == ($past(ctrl[ncofs_pkg::CTRL_FREQ_BIT]) ? $past(freq_word_b)
		: $past(freq_word_a)))
		else $error("control bit not steering frequency");
	chk_phase_index: assert property (@(posedge aclk) disable iff (!aresetn)
		!use_bits ##1 !use_bits |-> sel_ph == {$past(phase_choice_hi), $past(phase_choice_lo)})
		else $error("phase index not binary of sampled pins");
	chk_phase_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		use_bits |=> offset == $past(phase_offset_reg[{ctrl[ncofs_pkg::CTRL_PH_HI],
		ctrl[ncofs_pkg::CTRL_PH_LO]}]))
		else $error("control bits not steering phase");
	chk_offset_pick: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && $stable(sel_ph) |-> offset == $past(phase_offset_reg[sel_ph]))
		else $error("offset not the selected register");
	chk_no_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && $changed(step) |-> phase_acc == $past(phase_acc) + $past(step))
		else $error("accumulator jumped on selection change");
	chk_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
endmodule // ncofs_top

// [ncofs_ctrl_model.sv]
`timescale 1ns/1ps
module ncofs_ctrl_model (
	// clock
	input wire logic aclk,
	// requested choice
	input wire logic use_bits,
	input wire logic [2:0] want,
	// selection pins
	output logic freq_word_choice,
	output logic phase_choice_lo,
	output logic phase_choice_hi
);
	// pins move only just after an edge, never on it
	always @(posedge aclk) begin
		freq_word_choice <= use_bits ? 1'b0 : want[0];
		phase_choice_lo <= use_bits ? 1'b0 : want[1];
		phase_choice_hi <= use_bits ? 1'b0 : want[2];
	end
endmodule // ncofs_ctrl_model

// [nco_freq_phase_select_tb_top.sv]
`timescale 1ns/1ps
module nco_freq_phase_select_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic use_bits = 1'b0;
	logic [2:0] want = 3'h0;
	logic fsel, plo, phi, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rdata, acc, rd;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, rs;
	logic [11:0] tph;
	int failures = 0;
	int total_checks = 0;
	always #5 aclk = ~aclk;
	ncofs_ctrl_model ctl (.aclk(aclk), .use_bits(use_bits), .want(want),
		.freq_word_choice(fsel), .phase_choice_lo(plo), .phase_choice_hi(phi));
	ncofs_top dut (.aclk(aclk), .aresetn(aresetn), .freq_word_choice(fsel),
		.phase_choice_lo(plo), .phase_choice_hi(phi), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .phase_acc(acc), .table_phase(tph));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic wa;
		logic ww;
		wa = 1'b0;
		ww = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(wa && ww)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				wa = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				ww = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// bready a cycle late, so bvalid must hold
		@(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic step_is(input logic [31:0] s);
		logic [31:0] p;
		repeat (4) @(posedge aclk);
		p = acc;
		@(posedge aclk);
		check("step", acc - p, s);
	endtask
	task automatic ofs_is(input logic [11:0] o);
		logic [31:0] p;
		repeat (4) @(posedge aclk);
		p = acc;
		@(posedge aclk);
		check("table", {20'h0, tph}, {20'h0, p[31:20] + o});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdr(ncofs_pkg::OFF_CTRL, rd, rs);
		check("ctrl rst", rd, 32'h0000_0000);
		rdr(8'h40, rd, rs);
		check("unmapped rresp", {30'h0, rs}, {30'h0, ncofs_pkg::RESP_SLVERR});
		wr(8'h40, 32'h1234_5678, rs);
		check("unmapped bresp", {30'h0, rs}, {30'h0, ncofs_pkg::RESP_SLVERR});
		wr(ncofs_pkg::OFF_FREQ_A, 32'hAAAA_5555, rs);
		wstrb <= 4'h3;
		wr(ncofs_pkg::OFF_FREQ_A, 32'h0000_1234, rs);
		wstrb <= 4'hF;
		rdr(ncofs_pkg::OFF_FREQ_A, rd, rs);
		check("strobe merge", rd, 32'hAAAA_1234);
		$display("test regs done");
	endtask
	task automatic t_freq();
		logic [31:0] p;
		wr(ncofs_pkg::OFF_FREQ_A, 32'h0000_1000, rs);
		check("bresp ok", {30'h0, rs}, {30'h0, ncofs_pkg::RESP_OKAY});
		wr(ncofs_pkg::OFF_FREQ_B, 32'hF000_0003, rs);
		rdr(ncofs_pkg::OFF_FREQ_B, rd, rs);
		check("freq b", rd, 32'hF000_0003);
		want <= 3'h0;
		step_is(32'h0000_1000);
		want <= 3'h1;
		step_is(32'hF000_0003);
		want <= 3'h0;
		// pin seen one edge after the model moves it, step one edge later
		for (int i = 0; i < 6; i++) begin
			p = acc;
			@(posedge aclk);
			check("switch", acc - p, (i < 4) ? 32'hF000_0003 : 32'h0000_1000);
		end
		$display("test freq done");
	endtask
	task automatic t_phase();
		logic [11:0] o [4] = '{12'h123, 12'h456, 12'h789, 12'hABC};
		for (int i = 0; i < 4; i++) begin
			wr(ncofs_pkg::OFF_PHASE0 + 8'(4 * i), {20'hFFFFF, o[i]}, rs);
		end
		rdr(ncofs_pkg::OFF_PHASE3, rd, rs);
		check("phase3", rd, 32'h0000_0ABC);
		for (int i = 0; i < 4; i++) begin
			want <= {2'(i), 1'b0};
			ofs_is(o[i]);
		end
		$display("test phase done");
	endtask
	task automatic t_bits();
		logic [31:0] p;
		use_bits <= 1'b1;
		wr(ncofs_pkg::OFF_CTRL, 32'h0000_000D, rs);
		rdr(ncofs_pkg::OFF_STATUS, rd, rs);
		check("status", rd, 32'h0000_0005);
		step_is(32'hF000_0003);
		ofs_is(12'h789);
		wr(ncofs_pkg::OFF_CTRL, 32'h0000_000A, rs);
		step_is(32'h0000_1000);
		ofs_is(12'h456);
		// back to back reads take three edges apart
		rdr(ncofs_pkg::OFF_ACC, rd, rs);
		p = rd;
		rdr(ncofs_pkg::OFF_ACC, rd, rs);
		check("acc rresp", {30'h0, rs}, {30'h0, ncofs_pkg::RESP_OKAY});
		check("acc over reads", rd - p, 32'h0000_3000);
		$display("test bits done");
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_freq();
		t_phase();
		t_bits();
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		failures++;
		end_sim();
	end
endmodule // nco_freq_phase_select_tb_top
